/* verilog/bbm_cfg.svh */
// Register map, field positions and reset values of the breakpoint matcher
`ifndef BBM_CFG_SVH
`define BBM_CFG_SVH

`define BBM_OFS_ADDR     12'h000
`define BBM_OFS_CTRL     12'h004
`define BBM_OFS_STAT     12'h008
`define BBM_OFS_MASK     12'h00C

`define BBM_V_BIT        0
`define BBM_AS_LSB       1
`define BBM_AS_MSB       9
`define BBM_MA_LSB       10
`define BBM_MA_MSB       11
`define BBM_INV_BIT      12
`define BBM_SIZ_LSB      13
`define BBM_SIZ_MSB      14
`define BBM_SZIGN_BIT    15
`define BBM_RW_LSB       16
`define BBM_RW_MSB       17
`define BBM_BSEL_BIT     18
`define BBM_ACKE_BIT     19
`define BBM_CTRL_USED    32'h000F_FFFF

`define BBM_IRQ_BRK      0
`define BBM_IRQ_BUSERR   1
`define BBM_IRQ_USED     32'h0000_0003

`define BBM_ADDR_RST     32'h0000_0000
`define BBM_CTRL_RST     32'h0000_0000

`define BBM_MASK_2K      32'hFFFF_F800
`define BBM_MASK_8K      32'hFFFF_E000
`define BBM_MASK_32K     32'hFFFF_8000

`define BBM_FC_CPU       4'h7
`define BBM_TT_ACK       2'h3
`define BBM_TT_NORM      2'h0
`define BBM_ACK_TYPE     4'h0
`define BBM_ACK_LSB      16
`define BBM_ACK_MSB      19
`define BBM_AS_DMA       4'h8
`define BBM_AS_ACK       4'h7

`define BBM_CYC_W        46

`endif

/* verilog/bbm_pkg.sv */
// Types shared by the breakpoint matcher modules
package bbm_pkg;

  typedef enum logic [1:0] {
    BBM_SZ_LONG = 2'b00,
    BBM_SZ_BYTE = 2'b01,
    BBM_SZ_WORD = 2'b10,
    BBM_SZ_TRI  = 2'b11
  } bbm_size_t;

  typedef enum logic [1:0] {
    BBM_DIR_RD   = 2'b00,
    BBM_DIR_WR   = 2'b01,
    BBM_DIR_BOTH = 2'b10,
    BBM_DIR_RSV  = 2'b11
  } bbm_dir_t;

  typedef enum logic [1:0] {
    BBM_MA_NONE = 2'b00,
    BBM_MA_2K   = 2'b01,
    BBM_MA_8K   = 2'b10,
    BBM_MA_32K  = 2'b11
  } bbm_ma_t;

endpackage

/* verilog/bbm_cyc_if.sv */
// One monitored bus cycle as seen by the comparators
`timescale 1ns/1ps
`default_nettype none

interface bbm_cyc_if;
  logic                valid;
  logic [31:0]         addr;
  logic [1:0]          size;
  logic                rd;
  logic [3:0]          fc;
  logic                burst;
  logic [1:0]          tt;
  logic [2:0]          tm;
  logic                ext;

  modport src (output valid, addr, size, rd, fc, burst, tt, tm, ext);
  modport dst (input  valid, addr, size, rd, fc, burst, tt, tm, ext);
endinterface

`default_nettype wire

/* verilog/bbm_addr_cmp.sv */
// Address, block and size comparison of one bus cycle
`timescale 1ns/1ps
`default_nettype none
`include "bbm_cfg.svh"

module bbm_addr_cmp (
  bbm_cyc_if.dst              cyc,      // Cycle under test
  input  wire logic [31:0]    bka_i,    // Programmed address
  input  wire bbm_pkg::bbm_ma_t ma_i,   // Block size code
  input  wire logic           inv_i,    // Invert block match
  input  wire logic           szign_i,  // Size ignore
  input  wire bbm_pkg::bbm_size_t psz_i, // Programmed size
  output logic                hit_o     // Address part matches
);

  logic [2:0]  last_byte;
  logic [2:0]  len_m1;
  logic        overlap;
  logic        exact;
  logic [31:0] amask;

  // Last byte lane touched inside the long word
  always_comb begin
    case (cyc.size)
      bbm_pkg::BBM_SZ_LONG: len_m1 = 3'd3;
      bbm_pkg::BBM_SZ_BYTE: len_m1 = 3'd0;
      bbm_pkg::BBM_SZ_WORD: len_m1 = 3'd1;
      default:              len_m1 = 3'd2;
    endcase
    last_byte = {1'b0, cyc.addr[1:0]} + len_m1;
  end

  always_comb begin
    if (bka_i[1:0] == 2'b01) begin
      overlap = !((cyc.addr[1:0] == 2'b00) &&
                  (cyc.size == bbm_pkg::BBM_SZ_BYTE));
    end else begin
      overlap = (cyc.addr[1:0] <= bka_i[1:0]) &&
                (last_byte >= {1'b0, bka_i[1:0]});
    end
  end

  always_comb begin
    case (ma_i)
      bbm_pkg::BBM_MA_2K:  amask = `BBM_MASK_2K;
      bbm_pkg::BBM_MA_8K:  amask = `BBM_MASK_8K;
      bbm_pkg::BBM_MA_32K: amask = `BBM_MASK_32K;
      default:             amask = '1;
    endcase
  end

  // size checked only for unmasked internal cycles
  assign exact = !szign_i && !cyc.ext;

  always_comb begin
    if (ma_i == bbm_pkg::BBM_MA_NONE) begin
      if (exact) begin
        hit_o = (cyc.addr == bka_i) && (cyc.size == psz_i);
      end else begin
        hit_o = (cyc.addr[31:2] == bka_i[31:2]) && overlap;
      end
    end else begin
      hit_o = ((cyc.addr & amask) == (bka_i & amask)) ^ inv_i;
    end
  end

endmodule

`default_nettype wire

/* verilog/bbm_space_cmp.sv */
// Address space masking of one bus cycle
`timescale 1ns/1ps
`default_nettype none
`include "bbm_cfg.svh"

module bbm_space_cmp (
  bbm_cyc_if.dst              cyc,        // Cycle under test
  input  wire logic [8:0]     mask_i,     // Space mask bits
  output logic                blocked_o   // Space is masked
);

  logic [3:0] idx;
  logic       mapped;

  always_comb begin
    mapped = 1'b1;
    idx    = 4'h0;
    if (cyc.burst) begin
      // burst style cycles by transfer type and modifier
      if (cyc.tt == `BBM_TT_ACK) begin
        idx = `BBM_AS_ACK;
      end else if (cyc.tt == `BBM_TT_NORM) begin
        idx = {1'b0, cyc.tm};
      end else begin
        mapped = 1'b0;
      end
    end else begin
      // function code spaces, top bit is DMA
      idx = cyc.fc[3] ? `BBM_AS_DMA : {1'b0, cyc.fc[2:0]};
    end
  end

  assign blocked_o = mapped && mask_i[idx];

endmodule

`default_nettype wire

/* verilog/bbm_top.sv */
// Bus breakpoint matcher with APB registers and interrupt
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bbm_cfg.svh"

module bbm_top (
  input  wire logic        clk_i,        // 40 MHz clock
  input  wire logic        rst_n_i,      // Sync reset, active low
  input  wire logic        psel_i,       // APB select
  input  wire logic        penable_i,    // APB enable
  input  wire logic        pwrite_i,     // APB write
  input  wire logic [11:0] paddr_i,      // APB byte address
  input  wire logic [31:0] pwdata_i,     // APB write data
  output logic      [31:0] prdata_o,     // APB read data
  output logic             pready_o,     // APB ready
  output logic             pslverr_o,    // APB error, unmapped
  input  wire logic        ib_valid_i,   // Internal cycle valid
  input  wire logic [31:0] ib_addr_i,    // Internal address
  input  wire logic [1:0]  ib_size_i,    // Internal size lines
  input  wire logic        ib_read_i,    // Internal read cycle
  input  wire logic [3:0]  ib_fc_i,      // Internal function code
  input  wire logic        eb_valid_i,   // External cycle valid
  input  wire logic [31:0] eb_addr_i,    // External address
  input  wire logic [1:0]  eb_size_i,    // External size lines
  input  wire logic        eb_read_i,    // External read cycle
  input  wire logic [3:0]  eb_fc_i,      // External function code
  input  wire logic        eb_burst_i,   // External burst style
  input  wire logic [1:0]  eb_tt_i,      // External transfer type
  input  wire logic [2:0]  eb_tm_i,      // External modifier
  output logic             break_request_out_o, // Break request
  output logic             bus_error_out_o,     // Bus error
  output logic             irq_o         // Interrupt level
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and APB slave

  logic [31:0] breakpoint_address_reg_q;
  logic [31:0] breakpoint_control_reg_q;
  logic [31:0] irq_status_q;
  logic [31:0] irq_status_d;
  logic [31:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        wr_en;
  logic        setup;
  logic        mapped;
  logic [31:0] rd_mux;

  assign setup  = psel_i && !penable_i;
  assign wr_en  = psel_i && penable_i && pready_q && pwrite_i;
  assign mapped = (paddr_i == `BBM_OFS_ADDR) ||
                  (paddr_i == `BBM_OFS_CTRL) ||
                  (paddr_i == `BBM_OFS_STAT) ||
                  (paddr_i == `BBM_OFS_MASK);

  always_comb begin
    case (paddr_i)
      `BBM_OFS_ADDR: rd_mux = breakpoint_address_reg_q;
      `BBM_OFS_CTRL: rd_mux = breakpoint_control_reg_q;
      `BBM_OFS_STAT: rd_mux = irq_status_q;
      `BBM_OFS_MASK: rd_mux = irq_mask_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero wait states: ready rises in the first access cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= (setup && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      breakpoint_address_reg_q <= `BBM_ADDR_RST;
      breakpoint_control_reg_q <= `BBM_CTRL_RST;
      irq_mask_q               <= 32'h0000_0000;
    end else if (wr_en) begin
      if (paddr_i == `BBM_OFS_ADDR) begin
        breakpoint_address_reg_q <= pwdata_i;
      end
      if (paddr_i == `BBM_OFS_CTRL) begin
        breakpoint_control_reg_q <= pwdata_i & `BBM_CTRL_USED;
      end
      if (paddr_i == `BBM_OFS_MASK) begin
        irq_mask_q <= pwdata_i & `BBM_IRQ_USED;
      end
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // Control fields

  logic                entry_ok_flag;
  logic [8:0]          space_mask_bits;
  bbm_pkg::bbm_ma_t    block_size_code;
  logic                invert_block_match;
  bbm_pkg::bbm_size_t  prog_size;
  logic                size_ignore;
  bbm_pkg::bbm_dir_t   direction_select;
  logic                bus_source_select;
  logic                ack_cycle_error_enable;

  assign entry_ok_flag      = breakpoint_control_reg_q[`BBM_V_BIT];
  assign space_mask_bits    =
    breakpoint_control_reg_q[`BBM_AS_MSB:`BBM_AS_LSB];
  assign block_size_code    = bbm_pkg::bbm_ma_t'(
    breakpoint_control_reg_q[`BBM_MA_MSB:`BBM_MA_LSB]);
  assign invert_block_match = breakpoint_control_reg_q[`BBM_INV_BIT];
  assign prog_size          = bbm_pkg::bbm_size_t'(
    breakpoint_control_reg_q[`BBM_SIZ_MSB:`BBM_SIZ_LSB]);
  assign size_ignore        = breakpoint_control_reg_q[`BBM_SZIGN_BIT];
  assign direction_select   = bbm_pkg::bbm_dir_t'(
    breakpoint_control_reg_q[`BBM_RW_MSB:`BBM_RW_LSB]);
  assign bus_source_select  = breakpoint_control_reg_q[`BBM_BSEL_BIT];
  assign ack_cycle_error_enable =
    breakpoint_control_reg_q[`BBM_ACKE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // External bus synchroniser and cycle selection

  logic [`BBM_CYC_W-1:0] eb_raw;
  logic [`BBM_CYC_W-1:0] eb_s1_q;
  logic [`BBM_CYC_W-1:0] eb_s2_q;

  assign eb_raw = {eb_valid_i, eb_addr_i, eb_size_i, eb_read_i,
                   eb_fc_i, eb_burst_i, eb_tt_i, eb_tm_i};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      eb_s1_q <= '0;
      eb_s2_q <= '0;
    end else begin
      eb_s1_q <= eb_raw;
      eb_s2_q <= eb_s1_q;
    end
  end

  bbm_cyc_if cyc ();

  always_comb begin
    if (bus_source_select) begin
      {cyc.valid, cyc.addr, cyc.size, cyc.rd, cyc.fc, cyc.burst,
       cyc.tt, cyc.tm} = eb_s2_q;
      cyc.ext = 1'b1;
    end else begin
      cyc.valid = ib_valid_i;
      cyc.addr  = ib_addr_i;
      cyc.size  = bbm_pkg::bbm_size_t'(ib_size_i);
      cyc.rd    = ib_read_i;
      cyc.fc    = ib_fc_i;
      cyc.burst = 1'b0;
      cyc.tt    = 2'b00;
      cyc.tm    = 3'b000;
      cyc.ext   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparators and break request

  logic addr_hit;
  logic space_blocked;
  logic dir_ok;
  logic break_d;
  logic break_q;
  logic ack_cycle;
  logic buserr_d;
  logic buserr_q;

  bbm_addr_cmp u_addr (
    .cyc    (cyc),
    .bka_i  (breakpoint_address_reg_q),
    .ma_i   (block_size_code),
    .inv_i  (invert_block_match),
    .szign_i(size_ignore),
    .psz_i  (prog_size),
    .hit_o  (addr_hit)
  );

  bbm_space_cmp u_space (
    .cyc       (cyc),
    .mask_i    (space_mask_bits),
    .blocked_o (space_blocked)
  );

  // direction qualifier, reserved code never matches
  always_comb begin
    case (direction_select)
      bbm_pkg::BBM_DIR_RD:   dir_ok = cyc.rd;
      bbm_pkg::BBM_DIR_WR:   dir_ok = !cyc.rd;
      bbm_pkg::BBM_DIR_BOTH: dir_ok = 1'b1;
      default:               dir_ok = 1'b0;
    endcase
  end

  // valid entry, flag high in every clock that a matching cycle stays valid
  assign break_d = entry_ok_flag && cyc.valid && addr_hit &&
                   dir_ok && !space_blocked;

  // acknowledge cycle of the internal processor
  assign ack_cycle = ib_valid_i && (ib_fc_i == `BBM_FC_CPU) &&
                     (ib_addr_i[`BBM_ACK_MSB:`BBM_ACK_LSB] == `BBM_ACK_TYPE);
  assign buserr_d  = ack_cycle_error_enable && ack_cycle;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      break_q  <= 1'b0;
      buserr_q <= 1'b0;
    end else begin
      break_q  <= break_d;
      buserr_q <= buserr_d;
    end
  end

  assign break_request_out_o = break_q;
  assign bus_error_out_o     = buserr_q;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins

  logic irq_q;

  always_comb begin
    irq_status_d = irq_status_q;
    if (wr_en && (paddr_i == `BBM_OFS_STAT)) begin
      irq_status_d = irq_status_q & ~pwdata_i;
    end
    if (break_d) begin
      irq_status_d[`BBM_IRQ_BRK] = 1'b1;
    end
    if (buserr_d) begin
      irq_status_d[`BBM_IRQ_BUSERR] = 1'b1;
    end
    irq_status_d = irq_status_d & `BBM_IRQ_USED;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_status_q <= 32'h0000_0000;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_q        <= |(irq_status_d & irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_cyc_sel;
    cyc.valid && entry_ok_flag && dir_ok && !space_blocked;
  endsequence

  sequence s_no_break;
    ##1 !break_request_out_o;
  endsequence

  valid_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !entry_ok_flag |-> s_no_break)
    else $error("break raised without valid entry");

  dir_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (direction_select == bbm_pkg::BBM_DIR_WR) && cyc.rd |-> s_no_break)
    else $error("write-only entry broke on a read");

  space_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !cyc.burst && !cyc.fc[3] && space_mask_bits[cyc.fc[2:0]]
    |-> s_no_break)
    else $error("masked space produced a break");

  size_exact_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_cyc_sel ##0 (block_size_code == bbm_pkg::BBM_MA_NONE) &&
    !size_ignore && !bus_source_select
    |=> break_request_out_o ==
        $past(cyc.addr == breakpoint_address_reg_q &&
              cyc.size == prog_size))
    else $error("exact size compare wrong");

  low_bits_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    size_ignore && (block_size_code == bbm_pkg::BBM_MA_NONE) &&
    (breakpoint_address_reg_q[1:0] == 2'b00) &&
    (cyc.addr[1:0] != 2'b00) |-> s_no_break)
    else $error("offset 00 entry hit another offset");

  block_in_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_cyc_sel ##0 (block_size_code == bbm_pkg::BBM_MA_8K) &&
    !invert_block_match &&
    (cyc.addr[31:13] == breakpoint_address_reg_q[31:13])
    |=> break_request_out_o)
    else $error("cycle inside 8K block missed");

  block_inv_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (block_size_code == bbm_pkg::BBM_MA_2K) && invert_block_match &&
    (cyc.addr[31:11] == breakpoint_address_reg_q[31:11])
    |-> s_no_break)
    else $error("inverted block broke inside block");

  hold_cycle_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(cyc.valid) |=> !break_request_out_o)
    else $error("break outlived its cycle");

  ack_bus_error_out_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ack_cycle |=> bus_error_out_o == $past(ack_cycle_error_enable))
    else $error("bus error not tied to ack enable");

  irq_level_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    break_d && irq_mask_q[`BBM_IRQ_BRK] |=> irq_o)
    else $error("unmasked break event gave no interrupt");

endmodule

`default_nettype wire

/* bench/bbm_bus_model.sv */
// Bus master model driving internal and external monitored cycles
`timescale 1ns/1ps
`default_nettype none

module bbm_bus_model (
  input  wire logic        clk_i, // System clock
  output logic      [39:0] ib_o,  // Internal: valid, addr, size, read, fc
  output logic      [45:0] eb_o   // External: same plus burst, tt, tm
);
  initial begin
    ib_o = '0;
    eb_o = '0;
  end

  // One cycle; n clocks of hold on the external bus, so it can be slow
  task automatic beat(input logic ext, input logic [31:0] a,
                      input logic [1:0] s, input logic r,
                      input logic [3:0] f, input logic [5:0] btt,
                      input int unsigned n);
    if (ext) begin
      eb_o <= {1'b1, a, s, r, f, btt};
      repeat (n) @(posedge clk_i);
      // Released lines show the inverse so stale values cannot match
      eb_o <= {1'b0, ~a, ~s, ~r, ~f, ~btt};
    end else begin
      ib_o <= {1'b1, a, s, r, f};
      @(posedge clk_i);
      ib_o <= {1'b0, ~a, ~s, ~r, ~f};
    end
  endtask
endmodule

`default_nettype wire

/* bench/tb.sv */
// Self-checking testbench of the bus breakpoint matcher
`timescale 1ns/1ps
`default_nettype none
`include "bbm_cfg.svh"

module tb;
  localparam int          MAX_CYC = 20000;
  // Overlap table, bit index {programmed low bits, offset, size}
  localparam logic [63:0] OVL     = 64'hFD91_0FD9_FFFD_000F;
  logic        clk_i      = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        psel_i     = 1'b0;
  logic        penable_i  = 1'b0;
  logic        pwrite_i   = 1'b0;
  logic [11:0] paddr_i    = 12'h000;
  logic [31:0] pwdata_i   = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic        pready_o, pslverr_o, brk, buserr, irq, err;
  logic [39:0] ib;
  logic [45:0] eb;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          cycles     = 0;

  always #12.5 clk_i = ~clk_i;

  bbm_bus_model i_bus (.clk_i(clk_i), .ib_o(ib), .eb_o(eb));

  bbm_top i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ib_valid_i(ib[39]), .ib_addr_i(ib[38:7]),
    .ib_size_i(ib[6:5]), .ib_read_i(ib[4]), .ib_fc_i(ib[3:0]),
    .eb_valid_i(eb[45]), .eb_addr_i(eb[44:13]), .eb_size_i(eb[12:11]),
    .eb_read_i(eb[10]), .eb_fc_i(eb[9:6]), .eb_burst_i(eb[5]),
    .eb_tt_i(eb[4:3]), .eb_tm_i(eb[2:0]), .break_request_out_o(brk),
    .bus_error_out_o(buserr), .irq_o(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      num_errors++;
      $display("FAIL %0t run did not finish", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(err, 0);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(err, e);
  endtask

  task automatic wr_irq(input logic [11:0] a, input logic [31:0] d,
                        input logic exp);
    wr(a, d);
    @(posedge clk_i);
    #1;
    chk(irq, exp);
    @(posedge clk_i);
  endtask

  function automatic logic [31:0] ctl(input int as, ma, ng, sz, sm, rw,
                                      bs, ba);
    return {12'h000, ba[0], bs[0], rw[1:0], sm[0], sz[1:0], ng[0],
            ma[1:0], as[8:0], 1'b1};
  endfunction

  task automatic setup(input logic [31:0] a, input logic [31:0] c);
    wr(`BBM_OFS_ADDR, a);
    wr(`BBM_OFS_CTRL, c);
  endtask

  task automatic hit(input logic e, input logic [31:0] a,
                     input logic [1:0] s, input logic r, input logic [3:0] f,
                     input logic [5:0] t, input logic x);
    i_bus.beat(e, a, s, r, f, t, 4 + a[1:0]);
    #1;
    chk(brk, x);
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(`BBM_OFS_ADDR, 32'h0000_0000, 0);
    rchk(`BBM_OFS_CTRL, 32'h0000_0000, 0);
    rchk(`BBM_OFS_STAT, 32'h0000_0000, 0);
    rchk(`BBM_OFS_MASK, 32'h0000_0000, 0);
    rchk(12'h010, 32'h0000_0000, 1);
    #1;
    chk(pready_o, 0);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk(err, 1);
    wr(`BBM_OFS_CTRL, 32'hFFFF_FFFF);
    rchk(`BBM_OFS_CTRL, 32'h000F_FFFF, 0);
    wr(`BBM_OFS_ADDR, 32'hA5A5_5A5A);
    rchk(`BBM_OFS_ADDR, 32'hA5A5_5A5A, 0);
    wr(`BBM_OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic t_size();
    setup(32'h1000_0002, ctl(0, 0, 0, 2, 0, 2, 0, 0));
    hit(0, 32'h1000_0002, 2, 1, 1, 0, 1);
    hit(0, 32'h1000_0000, 0, 1, 1, 0, 0);
    wr(`BBM_OFS_CTRL, ctl(0, 0, 0, 2, 0, 2, 0, 0) & 32'hFFFF_FFFE);
    hit(0, 32'h1000_0002, 2, 1, 1, 0, 0);
    for (int p = 0; p < 4; p++) begin
      setup(32'h1000_0000, ctl(0, 0, 0, p, 0, 2, 0, 0));
      for (int s = 0; s < 4; s++) begin
        hit(0, 32'h1000_0000, s, 1, 1, 0, p == s);
      end
    end
    wr(`BBM_OFS_CTRL, ctl(0, 1, 0, 1, 0, 2, 0, 0));
    hit(0, 32'h1000_0000, 0, 1, 1, 0, 1);
  endtask

  task automatic t_ovl();
    for (int e = 0; e < 2; e++) begin
      for (int b = 0; b < 4; b++) begin
        setup(32'h2000_0000 + b, ctl(0, 0, 0, 0, 1 - e, 2, e, 0));
        for (int i = 0; i < 16; i++) begin
          hit(e, 32'h2000_0000 + i / 4, i, 1, 1, 0, OVL[b*16+i]);
        end
      end
    end
  endtask

  task automatic t_block();
    for (int m = 1; m < 4; m++) begin
      for (int n = 0; n < 2; n++) begin
        setup(32'h3000_0000, ctl(0, m, n, 0, 0, 2, 0, 0));
        hit(0, 32'h3000_0000 + (1 << (9 + 2 * m)) - 1, 0, 1, 1, 0, !n);
        hit(0, 32'h3000_0000 + (1 << (9 + 2 * m)), 0, 1, 1, 0, n);
      end
    end
    setup(32'h3000_0000, ctl(0, 0, 1, 0, 0, 2, 0, 0));
    hit(0, 32'h3000_0000, 0, 1, 1, 0, 1);
    hit(0, 32'h3000_0800, 0, 1, 1, 0, 0);
    setup(32'h3000_0000, ctl(2, 1, 1, 0, 0, 0, 0, 0));
    hit(0, 32'h3000_0800, 0, 1, 2, 0, 1);
    hit(0, 32'h3000_0800, 0, 0, 2, 0, 0);
    hit(0, 32'h3000_0800, 0, 1, 1, 0, 0);
  endtask

  task automatic t_space();
    for (int k = 0; k < 9; k++) begin
      setup(32'h4000_0000, ctl(1 << k, 0, 0, 0, 1, 2, 0, 0));
      hit(0, 32'h4000_0000, 0, 1, k == 8 ? 12 : k, 0, 0);
      hit(0, 32'h4000_0000, 0, 1, k == 8 ? 0 : 8, 0, 1);
      wr(`BBM_OFS_CTRL, ctl(1 << k, 0, 0, 0, 1, 2, 1, 0));
      hit(1, 32'h4000_0000, 0, 1, 0, k == 7 ? 56 : 32 + k % 8, k == 8);
    end
    for (int d = 0; d < 4; d++) begin
      setup(32'h5000_0000, ctl(0, 0, 0, 0, 1, d, 0, 0));
      hit(0, 32'h5000_0000, 0, 1, 1, 0, d == 0 || d == 2);
      hit(0, 32'h5000_0000, 0, 0, 1, 0, d == 1 || d == 2);
    end
  endtask

  task automatic t_irq();
    wr(`BBM_OFS_STAT, 32'h0000_0003);
    wr(`BBM_OFS_MASK, 32'h0000_0000);
    setup(32'h0000_0000, ctl(128, 0, 0, 0, 1, 2, 0, 1));
    i_bus.beat(0, 32'h0000_0000, 0, 1, 7, 0, 1);
    #1;
    chk(buserr, 1);
    chk(brk, 0);
    @(posedge clk_i);
    #1;
    chk(buserr, 0);
    @(posedge clk_i);
    hit(0, 32'h0000_0000, 0, 1, 1, 0, 1);
    #1;
    chk(brk, 0);
    @(posedge clk_i);
    rchk(`BBM_OFS_STAT, 32'h0000_0003, 0);
    wr_irq(`BBM_OFS_MASK, 32'h0000_0001, 1);
    wr_irq(`BBM_OFS_STAT, 32'h0000_0001, 0);
    wr_irq(`BBM_OFS_MASK, 32'h0000_0002, 1);
    wr_irq(`BBM_OFS_STAT, 32'h0000_0002, 0);
    rchk(`BBM_OFS_STAT, 32'h0000_0000, 0);
    wr(`BBM_OFS_CTRL, ctl(128, 0, 0, 0, 1, 2, 0, 0));
    i_bus.beat(0, 32'h0000_0000, 0, 1, 7, 0, 1);
    #1;
    chk(buserr, 0);
    @(posedge clk_i);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_size();
    t_ovl();
    t_block();
    t_space();
    t_irq();
    summarize();
  end
endmodule

`default_nettype wire
